// ### rst_int_regs.vh
// Constants for the reset and interrupt control block.
// Assumes a 16-bit CPU address space with the vector area at 1ff8 to 1fff.
`ifndef RST_INT_REGS_VH
`define RST_INT_REGS_VH
`define WDOG_CLR_ADDR 16'h1ff0
`define WDOG_CLR_BIT 0
`define VEC_RESET 16'h1ffe
`define VEC_TRAP 16'h1ffc
`define VEC_EXT 16'h1ffa
`define VEC_TIMER 16'h1ff8
`define POR_CYCLES 12'd4064
`define WDOG_STAGES 18
`define EXT_CLR_CYCLES 4'd9
`define UNUSED_VEC_LOW 8'h00
`endif

// ### ext_irq_detect.v
// External request detection: edge latch and optional level path.
// Assumes pins already synchronous to clk.
`timescale 1ns/10ps
`include "rst_int_regs.vh"
module ext_irq_detect #(
  parameter N = 8
) (
  input wire clk,
  input wire rstn,
  input wire ext_irq_n,
  input wire [N-1:0] port_irq_n,
  input wire port_irq_en,
  input wire level_mode,
  input wire latch_clr,
  output wire ext_req
);
  wire src_n;
  reg src_d_r;
  reg latch_r;
  assign src_n = ext_irq_n & (~port_irq_en | (&port_irq_n));
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_d_r <= 1'b1;
      latch_r <= 1'b0;
    end else begin
      src_d_r <= src_n;
      // Set wins over clear
      if (src_d_r & ~src_n)
        latch_r <= 1'b1;
      else if (latch_clr)
        latch_r <= 1'b0;
    end
  end
  assign ext_req = latch_r | (level_mode & ~src_n);
endmodule

// ### watchdog_counter.v
// Watchdog divider chain with service clear and timeout pulse.
// Assumes clk stops only when the oscillator stops.
`timescale 1ns/10ps
`include "rst_int_regs.vh"
module watchdog_counter #(
  parameter STAGES = `WDOG_STAGES
) (
  input wire clk,
  input wire rstn,
  input wire sys_rst,
  input wire service,
  input wire stopped,
  output wire timeout
);
  reg [STAGES-1:0] cnt_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      cnt_r <= {STAGES{1'b0}};
    else if (sys_rst | service)
      cnt_r <= {STAGES{1'b0}};
    else if (!stopped)
      cnt_r <= cnt_r + {{(STAGES-1){1'b0}}, 1'b1};
  end
  assign timeout = &cnt_r;
endmodule

// ### reset_and_interrupt_control.v
// Reset generation and interrupt arbitration for a small 8-bit CPU.
// Assumes CPU pulses inst_done at instruction end, with trap_op and return_op alongside.
`timescale 1ns/10ps
`include "rst_int_regs.vh"
module reset_and_interrupt_control #(
  parameter PORT_N = 8,
  parameter WDOG_STAGES = `WDOG_STAGES,
  parameter [11:0] POR_CYCLES = `POR_CYCLES
) (
  input wire clk,
  input wire rstn,
  input wire ext_reset_n,
  input wire osc_running,
  input wire stop_mode,
  input wire watchdog_enable,
  input wire level_mode,
  input wire port_irq_en,
  input wire prog_voltage,
  input wire ext_irq_n,
  input wire [PORT_N-1:0] port_irq_n,
  input wire [2:0] timer_status_flags,
  input wire [2:0] timer_control_en,
  input wire cond_mask,
  input wire inst_done,
  input wire trap_op,
  input wire return_op,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output reg rdata_valid,
  output reg sys_rst,
  output reg take_irq,
  output reg [15:0] vector_addr,
  output reg set_mask,
  output reg push_state,
  output reg pop_state,
  output reg wdog_reset_seen,
  output reg [1:0] state
);
  localparam S_RUN = 2'd0;
  localparam S_VEC = 2'd1;
  localparam S_CLR = 2'd2;
  localparam [3:0] CLR_LAST = `EXT_CLR_CYCLES - 4'd1;
  localparam [11:0] POR_LAST = POR_CYCLES - 12'h001;

  reg [11:0] por_cnt_r;
  reg por_active_r;
  reg ext_clr_r;
  reg [3:0] clr_cnt_r;
  reg [1:0] state_nxt;
  reg [15:0] vector_nxt;
  reg [7:0] rd_word;
  wire ext_req;
  wire wdog_to;
  wire service;
  wire wdog_rst;
  wire timer_req;
  wire hw_pending;
  wire [2:0] timer_hit;
  wire wdog_addr_hit;
  wire por_last;
  wire por_step;
  wire sys_rst_nxt;
  wire enter_vec;
  wire leave_clr;
  wire ext_vectored;

  assign wdog_addr_hit = (addr == `WDOG_CLR_ADDR);
  assign service = wr & wdog_addr_hit & ~wdata[`WDOG_CLR_BIT];
  assign wdog_rst = wdog_to & watchdog_enable & ~prog_voltage;
  assign por_last = (por_cnt_r == POR_LAST);
  assign por_step = osc_running & por_active_r;
  assign sys_rst_nxt = por_active_r | ~ext_reset_n | wdog_rst;
  assign hw_pending = ~cond_mask & (ext_req | timer_req);
  assign enter_vec = (state == S_RUN) & (state_nxt == S_VEC);
  assign leave_clr = (state == S_CLR) & (state_nxt == S_RUN);
  assign ext_vectored = (vector_addr == `VEC_EXT);

  // One request term per timer source
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_timer
      assign timer_hit[g] = timer_status_flags[g] & timer_control_en[g];
    end
  endgenerate
  assign timer_req = |timer_hit;

  watchdog_counter #(.STAGES(WDOG_STAGES)) u_wdog (
    .clk(clk),
    .rstn(rstn),
    .sys_rst(sys_rst),
    .service(service),
    .stopped(stop_mode),
    .timeout(wdog_to)
  );

  ext_irq_detect #(.N(PORT_N)) u_ext (
    .clk(clk),
    .rstn(rstn),
    .ext_irq_n(ext_irq_n),
    .port_irq_n(port_irq_n),
    .port_irq_en(port_irq_en),
    .level_mode(level_mode),
    .latch_clr(ext_clr_r),
    .ext_req(ext_req)
  );

  // Stabilization count advances only while the oscillator runs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt_r <= 12'h000;
    end else if (por_step && !por_last) begin
      por_cnt_r <= por_cnt_r + 12'h001;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_active_r <= 1'b1;
    end else if (por_step && por_last) begin
      por_active_r <= 1'b0;
    end
  end

  // Registered OR of every reset source
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_rst <= 1'b1;
    end else begin
      sys_rst <= sys_rst_nxt;
    end
  end

  // Sticky watchdog cause; a new timeout wins over a service write
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdog_reset_seen <= 1'b0;
    end else if (wdog_rst) begin
      wdog_reset_seen <= 1'b1;
    end else if (service) begin
      wdog_reset_seen <= 1'b0;
    end
  end

  always @* begin
    state_nxt = state;
    case (state)
      S_RUN: begin
        if (inst_done && (hw_pending || trap_op)) begin
          state_nxt = S_VEC;
        end
      end
      S_VEC: begin
        if (ext_vectored) begin
          state_nxt = S_CLR;
        end else begin
          state_nxt = S_RUN;
        end
      end
      S_CLR: begin
        if (clr_cnt_r == CLR_LAST) begin
          state_nxt = S_RUN;
        end
      end
      default: begin
        state_nxt = S_RUN;
      end
    endcase
  end

  // Pending hardware requests precede the trap
  always @* begin
    vector_nxt = `VEC_TRAP;
    if (hw_pending && ext_req) begin
      vector_nxt = `VEC_EXT;
    end else if (hw_pending) begin
      vector_nxt = `VEC_TIMER;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_RUN;
    end else if (sys_rst) begin
      state <= S_RUN;
    end else begin
      state <= state_nxt;
    end
  end

  // Held high during reset so the core fetches the reset vector
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      take_irq <= 1'b0;
    end else if (sys_rst) begin
      take_irq <= 1'b1;
    end else begin
      take_irq <= enter_vec;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      push_state <= 1'b0;
    end else if (sys_rst) begin
      push_state <= 1'b0;
    end else begin
      push_state <= enter_vec;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      set_mask <= 1'b1;
    end else if (sys_rst) begin
      set_mask <= 1'b1;
    end else begin
      set_mask <= enter_vec;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pop_state <= 1'b0;
    end else if (sys_rst) begin
      pop_state <= 1'b0;
    end else begin
      pop_state <= inst_done & return_op;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vector_addr <= `VEC_RESET;
    end else if (sys_rst) begin
      vector_addr <= `VEC_RESET;
    end else if (enter_vec) begin
      vector_addr <= vector_nxt;
    end
  end

  // Counts cycles from recognition until the latch clear
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clr_cnt_r <= 4'h0;
    end else if (sys_rst) begin
      clr_cnt_r <= 4'h0;
    end else if (enter_vec) begin
      clr_cnt_r <= 4'h1;
    end else if (state != S_RUN) begin
      clr_cnt_r <= clr_cnt_r + 4'h1;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_clr_r <= 1'b0;
    end else if (sys_rst) begin
      ext_clr_r <= 1'b0;
    end else begin
      ext_clr_r <= leave_clr;
    end
  end

  // Shared service location: reads have no side effect
  always @* begin
    rd_word = 8'h00;
    if (rd && wdog_addr_hit) begin
      rd_word = `UNUSED_VEC_LOW;
    end else if (rd) begin
      rd_word = {7'h00, wdog_reset_seen};
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= rd;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd_word;
    end
  end
endmodule

// ### ric_sva.sv
// Port checker for the reset and interrupt control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module ric_sva (
  input wire clk,
  input wire rstn,
  input wire ext_reset_n,
  input wire watchdog_enable,
  input wire prog_voltage,
  input wire [2:0] timer_status_flags,
  input wire [2:0] timer_control_en,
  input wire cond_mask,
  input wire inst_done,
  input wire trap_op,
  input wire [15:0] addr,
  input wire rd,
  input wire [7:0] rdata,
  input wire rdata_valid,
  input wire sys_rst,
  input wire take_irq,
  input wire [15:0] vector_addr,
  input wire set_mask,
  input wire push_state,
  input wire [1:0] state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // External service keeps the arbiter busy until the latch clears
  sequence ext_busy;
    (state == 2'd2)[*7] ##1 (state == 2'd0);
  endsequence
  a_mask_blocks: assert property (inst_done && cond_mask && !trap_op && !sys_rst |=> !take_irq || sys_rst)
    else $error("interrupt taken while masked");
  a_vec_area: assert property (take_irq |-> vector_addr[15:3] == 13'h03ff && !vector_addr[0])
    else $error("vector outside top eight bytes");
  a_take_stacks: assert property (take_irq && !sys_rst && !$past(sys_rst) |-> push_state && set_mask)
    else $error("take without stacking or masking");
  a_wdog_read: assert property (rd && addr == 16'h1ff0 |=> rdata_valid && rdata == 8'h00)
    else $error("service location read wrong");
  a_ext_reset_holds: assert property (!ext_reset_n |=> sys_rst)
    else $error("reset dropped while pin low");
  a_wdog_off: assert property ((!watchdog_enable || prog_voltage) && ext_reset_n && !sys_rst |=> !sys_rst)
    else $error("watchdog reset while suppressed");
  a_trap_vector: assert property (inst_done && trap_op && cond_mask && state == 2'd0 && !sys_rst
    |=> take_irq && vector_addr == 16'h1ffc)
    else $error("trap not vectored");
  a_timer_cause: assert property (take_irq && vector_addr == 16'h1ff8
    |-> $past(|(timer_status_flags & timer_control_en)))
    else $error("timer vector without enabled flag");
  a_ext_latch_clr: assert property (take_irq && vector_addr == 16'h1ffa && !sys_rst |=> ext_busy)
    else $error("external service span wrong");
endmodule
bind reset_and_interrupt_control ric_sva i_sva (.*);

// ### cpu_model.sv
// CPU core stand-in: ends an instruction every fourth cycle while state is S_RUN and neither take_irq nor sys_rst is high.
// Assumes the controller's take and state outputs.
`timescale 1ns/10ps
module cpu_model (
  input wire clk,
  input wire rstn,
  input wire sys_rst,
  input wire [1:0] state,
  input wire take_irq,
  input wire trap_req,
  output reg inst_done,
  output reg trap_op,
  output reg return_op
);
  reg [1:0] gap_r;
  reg isr_r;
  reg rst_d_r;
  wire go = &gap_r && state == 2'h0 && !take_irq && !sys_rst;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_r <= 2'h0;
      isr_r <= 1'b0;
      rst_d_r <= 1'b1;
      inst_done <= 1'b0;
      trap_op <= 1'b0;
      return_op <= 1'b0;
    end else begin
      gap_r <= gap_r + 2'h1;
      rst_d_r <= sys_rst;
      inst_done <= go;
      trap_op <= go && trap_req;
      return_op <= go && isr_r;
      if (take_irq && !rst_d_r)
        isr_r <= 1'b1;
      else if (go)
        isr_r <= 1'b0;
    end
  end
endmodule

// ### reset_and_interrupt_control_tb.sv
// Testbench for reset_and_interrupt_control with a CPU stand-in.
// Assumes shortened power-on and watchdog counts.
`timescale 1ns/10ps
module reset_and_interrupt_control_tb;
  reg clk = 0, rstn = 0, ext_reset_n = 1, stop_mode = 0, watchdog_enable = 0, level_mode = 0, port_irq_en = 0;
  reg prog_voltage = 0, ext_irq_n = 1, cond_mask = 1, wr = 0, rd = 0, trap_req = 0, m, osc_running = 0;
  reg [7:0] port_irq_n = 8'hff, wdata = 8'h00;
  reg [2:0] tsf = 3'h0, tce = 3'h0, f, e;
  reg [15:0] addr = 16'h0000;
  wire [7:0] rdata;
  wire [15:0] vector_addr;
  wire [1:0] state;
  wire rdata_valid, sys_rst, take_irq, set_mask, push_state, pop_state, wdog_seen, inst_done, trap_op, return_op;
  integer err_total = 0, checks_done = 0, seed = 77, i, n, takes = 0, pops = 0;
  always #5 clk = ~clk;
  reset_and_interrupt_control #(.WDOG_STAGES(6), .POR_CYCLES(12'd8)) i_dut (.clk(clk), .rstn(rstn),
    .ext_reset_n(ext_reset_n), .osc_running(osc_running), .stop_mode(stop_mode), .watchdog_enable(watchdog_enable),
    .level_mode(level_mode), .port_irq_en(port_irq_en), .prog_voltage(prog_voltage), .ext_irq_n(ext_irq_n),
    .port_irq_n(port_irq_n), .timer_status_flags(tsf), .timer_control_en(tce), .cond_mask(cond_mask),
    .inst_done(inst_done), .trap_op(trap_op), .return_op(return_op), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rdata_valid(rdata_valid), .sys_rst(sys_rst), .take_irq(take_irq),
    .vector_addr(vector_addr), .set_mask(set_mask), .push_state(push_state), .pop_state(pop_state),
    .wdog_reset_seen(wdog_seen), .state(state));
  cpu_model i_cpu (.clk(clk), .rstn(rstn), .sys_rst(sys_rst), .state(state), .take_irq(take_irq),
    .trap_req(trap_req), .inst_done(inst_done), .trap_op(trap_op), .return_op(return_op));
  always @(posedge clk) begin
    takes = takes + (take_irq === 1'b1);
    pops = pops + (pop_state === 1'b1);
  end
  task check(input [16:0] seen, input [16:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      if (err_total == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task wr_reg(input [15:0] a);
    begin
      @(posedge clk);
      addr <= a;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
    end
  endtask
  task rd_reg(input [15:0] a, input [7:0] x);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 check({8'h00, rdata_valid, rdata}, {9'h001, x});
    end
  endtask
  // Records the first vector taken in a window, then drops the sources
  task expect_take(input [15:0] v, input en);
    reg got;
    reg [15:0] seen;
    begin
      got = 0;
      seen = 16'h0000;
      repeat (40) begin
        @(posedge clk);
        #1;
        if (take_irq === 1'b1 && !got) begin
          got = 1;
          seen = vector_addr;
        end
      end
      check({got, seen}, {en, en ? v : 16'h0000});
      @(posedge clk);
      tsf <= 3'h0;
      ext_irq_n <= 1;
      port_irq_n <= 8'hff;
      trap_req <= 0;
      repeat (15) @(posedge clk);
    end
  endtask
  initial begin
    #100000;
    err_total = err_total + 1;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clk);
    check({1'b0, vector_addr}, 17'h1ffe);
    rstn <= 1;
    repeat (5) @(posedge clk);
    #1 check({16'h0, sys_rst}, 17'h1);
    @(posedge clk);
    osc_running <= 1;
    n = 0;
    while (sys_rst !== 1'b0 && n < 50) begin
      @(posedge clk);
      n = n + 1;
    end
    check({16'h0, n >= 8 && n <= 11}, 17'h1);
    rd_reg(16'h1ff0, 8'h00);
    rd_reg(16'h1234, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      f = (i < 3) ? 3'h1 << i : $random(seed);
      e = (i < 3) ? f : $random(seed);
      m = (i < 3) ? 1'b0 : $random(seed);
      @(posedge clk);
      tsf <= f;
      tce <= e;
      cond_mask <= m;
      expect_take(16'h1ff8, !m && |(f & e));
    end
    @(posedge clk);
    cond_mask <= 1;
    ext_irq_n <= 0;
    expect_take(16'h0000, 0);
    @(posedge clk);
    cond_mask <= 0;
    tsf <= 3'h7;
    tce <= 3'h7;
    expect_take(16'h1ffa, 1);
    for (i = 0; i < 2; i = i + 1) begin
      n = $random(seed) & 7;
      @(posedge clk);
      port_irq_en <= i[0];
      port_irq_n[n] <= 1'b0;
      expect_take(16'h1ffa, i[0]);
    end
    for (i = 0; i < 2; i = i + 1) begin
      takes = 0;
      @(posedge clk);
      level_mode <= i[0];
      ext_irq_n <= 0;
      repeat (60) @(posedge clk);
      #1 check({16'h0, takes > 1}, {16'h0, i[0]});
      @(posedge clk);
      ext_irq_n <= 1;
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    cond_mask <= 1;
    trap_req <= 1;
    expect_take(16'h1ffc, 1);
    check({16'h0, pops > 0}, 17'h1);
    @(posedge clk);
    ext_reset_n <= 0;
    repeat (3) @(posedge clk);
    #1 check({16'h0, sys_rst}, 17'h1);
    @(posedge clk);
    ext_reset_n <= 1;
    repeat (30) @(posedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      wr_reg(16'h1ff0);
      watchdog_enable <= 1;
      repeat (40) @(posedge clk);
      #1 check({16'h0, sys_rst}, 17'h0);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wr_reg(16'h1ff0);
      prog_voltage <= !i[0];
      stop_mode <= i[0];
      repeat (150) @(posedge clk);
      #1 check({16'h0, sys_rst}, 17'h0);
    end
    wr_reg(16'h1ff0);
    prog_voltage <= 0;
    stop_mode <= 0;
    repeat (100) @(posedge clk);
    watchdog_enable <= 0;
    repeat (30) @(posedge clk);
    rd_reg(16'h0001, 8'h01);
    complete_run;
  end
endmodule
